/* File: pkg/qfd_pkg.sv */
// Package for the quad serial flash command decoder: opcodes, framing types, constants.
//
// Functional notes
// - 6Ch frames 1-1-(4), four address bytes, eight dummies
// - ECh/EEh four-lane address, six dummies, EEh marked dual_edge but framed like ECh on rising edges
// - 06h, 04h, 50h are opcode-only
// - 05h, 70h, C8h return register byte until deselect
// - B5h/85h address, eight dummies, one byte out
// - Program takes 1 to 256 bytes, no dummies
// - Erase opcodes carry address only
// - Suspend and resume are opcode-only
// - Security read, program and erase framing
// - B7h and E9h are opcode-only
// - 36h/39h lock opcodes address-only, 7Eh/98h opcode-only, read-lock returns one byte
// - Four-lane mode reset opcodes are opcode-only
// - Four-lane mode ID read outputs on four lanes
// - Shift MSB first, sample on rising edges
// - Reject writes not ending on byte boundary
// - Four-byte mode selects 32-bit addresses
// - Raising select ends any read transfer
`default_nettype none
package qfd_pkg;
  // Opcodes
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_ID_A = 8'h9e;
  localparam logic [7:0] OP_ID_B = 8'h9f;
  localparam logic [7:0] OP_RD4_QO = 8'h6c;
  localparam logic [7:0] OP_RD4_QIO = 8'hec;
  localparam logic [7:0] OP_RD4_QIO_DE = 8'hee;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_WR_EN_VOL = 8'h50;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_RD_FLAG = 8'h70;
  localparam logic [7:0] OP_RD_NVCFG = 8'hb5;
  localparam logic [7:0] OP_RD_VCFG = 8'h85;
  localparam logic [7:0] OP_RD_EXTA = 8'hc8;
  localparam logic [7:0] OP_WR_STAT = 8'h01;
  localparam logic [7:0] OP_WR_NVCFG = 8'hb1;
  localparam logic [7:0] OP_WR_VCFG = 8'h81;
  localparam logic [7:0] OP_WR_EXTA = 8'hc5;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_PP_Q = 8'h32;
  localparam logic [7:0] OP_PP_QX = 8'hc2;
  localparam logic [7:0] OP_PP4 = 8'h12;
  localparam logic [7:0] OP_PP4_Q = 8'h34;
  localparam logic [7:0] OP_PP4_QX = 8'h3e;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hd8;
  localparam logic [7:0] OP_SE4 = 8'h21;
  localparam logic [7:0] OP_BE32_4 = 8'h5c;
  localparam logic [7:0] OP_BE64_4 = 8'hdc;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_SEC_RD = 8'h48;
  localparam logic [7:0] OP_SEC_PP = 8'h42;
  localparam logic [7:0] OP_SEC_ER = 8'h44;
  localparam logic [7:0] OP_EN4B = 8'hb7;
  localparam logic [7:0] OP_DIS4B = 8'he9;
  localparam logic [7:0] OP_LOCK = 8'h36;
  localparam logic [7:0] OP_UNLOCK = 8'h39;
  localparam logic [7:0] OP_RD_LOCK = 8'h3d;
  localparam logic [7:0] OP_GLOCK = 8'h7e;
  localparam logic [7:0] OP_GUNLOCK = 8'h98;
  // Counts
  localparam logic [4:0] DUMMY_8 = 5'h08;
  localparam logic [4:0] DUMMY_6 = 5'h06;
  localparam logic [4:0] DUMMY_0 = 5'h00;
  localparam logic [2:0] ADDR_3B = 3'h3;
  localparam logic [2:0] ADDR_4B = 3'h4;
  localparam logic [8:0] PROG_MAX = 9'h100;
  localparam logic [1:0] SYNC_STAGES_RST = 2'h0;
  // Data phase kinds
  typedef enum logic [2:0] {
    QFD_DATA_NONE = 3'h0,
    QFD_DATA_IN = 3'h1,
    QFD_DATA_OUT = 3'h2,
    QFD_DATA_OUT_ONE = 3'h3
  } qfd_data_t;
  // Framing of one command
  typedef struct packed {
    logic known;
    logic opcode_only_reject; // must end on a byte boundary
    logic quad_addr;
    logic quad_data;
    logic dual_edge;
    logic [2:0] addr_bytes;
    logic [4:0] dummy;
    qfd_data_t data;
  } qfd_frame_t;
  // Decoded event toward the core
  typedef struct packed {
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [8:0] data_count;
    logic [7:0] last_byte;
  } qfd_cmd_t;
endpackage
`default_nettype wire

/* File: logic/qfd_decoder.sv */
// Quad serial flash command decoder and transaction framer.
`default_nettype none
module qfd_decoder (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe_out,
  input wire logic quad_mode_in,
  input wire logic [7:0] stat_reg_in,
  input wire logic [7:0] flag_reg_in,
  input wire logic [7:0] exta_reg_in,
  input wire logic [7:0] cfg_reg_in,
  input wire logic [7:0] mem_byte_in,
  output logic cmd_valid_out,
  output qfd_pkg::qfd_cmd_t cmd_out,
  output logic addr4_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Opcode table
  function automatic qfd_pkg::qfd_frame_t decode(input logic [7:0] op, input logic quad,
                                                 input logic a4);
    qfd_pkg::qfd_frame_t f;
    logic [2:0] sel;
    f = '0;
    sel = a4 ? qfd_pkg::ADDR_4B : qfd_pkg::ADDR_3B;
    f.known = 1'b1;
    if (quad) begin
      // Four-lane command mode: few entries supported
      f.quad_addr = 1'b1;
      f.quad_data = 1'b1;
      case (op)
        qfd_pkg::OP_RST_EN, qfd_pkg::OP_RST: f.opcode_only_reject = 1'b1;
        qfd_pkg::OP_ID_A, qfd_pkg::OP_ID_B: f.data = qfd_pkg::QFD_DATA_OUT;
        default: f.known = 1'b0;
      endcase
    end else begin
      case (op)
        qfd_pkg::OP_RD4_QO: begin
          f.addr_bytes = qfd_pkg::ADDR_4B;
          f.dummy = qfd_pkg::DUMMY_8;
          f.quad_data = 1'b1;
          f.data = qfd_pkg::QFD_DATA_OUT;
        end
        qfd_pkg::OP_RD4_QIO, qfd_pkg::OP_RD4_QIO_DE: begin
          f.addr_bytes = qfd_pkg::ADDR_4B;
          f.dummy = qfd_pkg::DUMMY_6;
          f.quad_addr = 1'b1;
          f.quad_data = 1'b1;
          f.dual_edge = (op == qfd_pkg::OP_RD4_QIO_DE);
          f.data = qfd_pkg::QFD_DATA_OUT;
        end
        qfd_pkg::OP_WR_EN, qfd_pkg::OP_WR_DIS, qfd_pkg::OP_WR_EN_VOL: begin
          f.opcode_only_reject = 1'b1;
        end
        qfd_pkg::OP_SUSP, qfd_pkg::OP_RESUME: begin
          f.opcode_only_reject = 1'b1;
        end
        qfd_pkg::OP_EN4B, qfd_pkg::OP_DIS4B, qfd_pkg::OP_GLOCK,
        qfd_pkg::OP_GUNLOCK: begin
          f.opcode_only_reject = 1'b1;
        end
        qfd_pkg::OP_RD_STAT, qfd_pkg::OP_RD_FLAG, qfd_pkg::OP_RD_EXTA: begin
          f.data = qfd_pkg::QFD_DATA_OUT;
        end
        qfd_pkg::OP_RD_NVCFG, qfd_pkg::OP_RD_VCFG: begin
          f.addr_bytes = sel;
          f.dummy = qfd_pkg::DUMMY_8;
          f.data = qfd_pkg::QFD_DATA_OUT_ONE;
        end
        qfd_pkg::OP_WR_STAT, qfd_pkg::OP_WR_EXTA: begin
          f.opcode_only_reject = 1'b1;
          f.data = qfd_pkg::QFD_DATA_IN;
        end
        qfd_pkg::OP_WR_NVCFG, qfd_pkg::OP_WR_VCFG: begin
          f.opcode_only_reject = 1'b1;
          f.addr_bytes = sel;
          f.data = qfd_pkg::QFD_DATA_IN;
        end
        qfd_pkg::OP_PP, qfd_pkg::OP_PP_Q, qfd_pkg::OP_PP_QX, qfd_pkg::OP_SEC_PP: begin
          f.opcode_only_reject = 1'b1;
          f.addr_bytes = sel;
          f.quad_data = (op == qfd_pkg::OP_PP_Q) || (op == qfd_pkg::OP_PP_QX);
          f.quad_addr = (op == qfd_pkg::OP_PP_QX);
          f.data = qfd_pkg::QFD_DATA_IN;
        end
        qfd_pkg::OP_PP4, qfd_pkg::OP_PP4_Q, qfd_pkg::OP_PP4_QX: begin
          f.opcode_only_reject = 1'b1;
          f.addr_bytes = qfd_pkg::ADDR_4B;
          f.quad_data = (op != qfd_pkg::OP_PP4);
          f.quad_addr = (op == qfd_pkg::OP_PP4_QX);
          f.data = qfd_pkg::QFD_DATA_IN;
        end
        qfd_pkg::OP_SE, qfd_pkg::OP_BE32, qfd_pkg::OP_BE64, qfd_pkg::OP_SEC_ER,
        qfd_pkg::OP_LOCK, qfd_pkg::OP_UNLOCK: begin
          f.opcode_only_reject = 1'b1;
          f.addr_bytes = sel;
        end
        qfd_pkg::OP_SE4, qfd_pkg::OP_BE32_4, qfd_pkg::OP_BE64_4: begin
          f.opcode_only_reject = 1'b1;
          f.addr_bytes = qfd_pkg::ADDR_4B;
        end
        qfd_pkg::OP_SEC_RD: begin
          f.addr_bytes = sel;
          f.dummy = qfd_pkg::DUMMY_8;
          f.data = qfd_pkg::QFD_DATA_OUT;
        end
        qfd_pkg::OP_RD_LOCK: begin
          f.addr_bytes = sel;
          f.dummy = qfd_pkg::DUMMY_0;
          f.data = qfd_pkg::QFD_DATA_OUT_ONE;
        end
        default: f.known = 1'b0;
      endcase
    end
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: runs on the host's serial clock, reset by deselect
  typedef enum logic [4:0] {
    QFD_ST_OP = 5'b00001,
    QFD_ST_ADDR = 5'b00010,
    QFD_ST_DUMMY = 5'b00100,
    QFD_ST_DATA = 5'b01000,
    QFD_ST_IDLE = 5'b10000
  } qfd_state_t;

  qfd_state_t state;
  qfd_pkg::qfd_frame_t frame;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic [7:0] opcode;
  logic [31:0] addr;
  logic [2:0] addr_left;
  logic [4:0] dummy_left;
  logic [8:0] data_count;
  logic [7:0] last_byte;
  logic [7:0] out_byte;
  logic out_hi;
  logic [7:0] nib_byte;
  logic [2:0] lane_bits;
  logic [7:0] next_shreg;
  logic [3:0] in_bits;
  logic byte_done;
  qfd_pkg::qfd_frame_t dec_frame;
  logic addr4_sync1;
  logic addr4_sync2;
  logic [7:0] src_byte;

  // Quad lanes move four bits per edge, single lane one
  always_comb begin
    logic wide;
    wide = 1'b0;
    case (state)
      QFD_ST_OP: wide = quad_mode_in;
      QFD_ST_ADDR: wide = frame.quad_addr;
      QFD_ST_DATA: wide = frame.quad_data;
      default: wide = 1'b0;
    endcase
    lane_bits = wide ? 3'h4 : 3'h1;
    in_bits = dq_in;
    next_shreg = wide ? {shreg[3:0], in_bits} : {shreg[6:0], in_bits[0]};
    byte_done = ((bitcnt + lane_bits) == 3'h0) ||
                (wide && (bitcnt == 3'h4));
  end

  assign dec_frame = decode(next_shreg, quad_mode_in, addr4_sync2);

  // Four-byte address flag crosses in from core, held steady between frames
  always_ff @(posedge sclk_in) begin
    addr4_sync1 <= addr4_out;
    addr4_sync2 <= addr4_sync1;
  end

  // Register value chosen by opcode; sampled inputs are quasi-static
  always_comb begin
    case (opcode)
      qfd_pkg::OP_RD_STAT: src_byte = stat_reg_in;
      qfd_pkg::OP_RD_FLAG: src_byte = flag_reg_in;
      qfd_pkg::OP_RD_EXTA: src_byte = exta_reg_in;
      qfd_pkg::OP_RD_NVCFG, qfd_pkg::OP_RD_VCFG, qfd_pkg::OP_RD_LOCK: src_byte = cfg_reg_in;
      default: src_byte = mem_byte_in;
    endcase
  end

  // Framing sequencer; deselect is its asynchronous reset, as on the pin
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      state <= QFD_ST_OP;
      bitcnt <= 3'h0;
      shreg <= 8'h00;
      opcode <= 8'h00;
      frame <= '0;
      addr <= 32'h0;
      addr_left <= 3'h0;
      dummy_left <= 5'h00;
      data_count <= 9'h000;
      last_byte <= 8'h00;
    end else begin
      shreg <= next_shreg;
      bitcnt <= byte_done ? 3'h0 : bitcnt + lane_bits;
      case (state)
        QFD_ST_OP: if (byte_done) begin
          opcode <= next_shreg;
          frame <= dec_frame;
          addr_left <= dec_frame.addr_bytes;
          dummy_left <= dec_frame.dummy;
          if (!dec_frame.known) state <= QFD_ST_IDLE;
          else if (dec_frame.addr_bytes != 3'h0) state <= QFD_ST_ADDR;
          else if (dec_frame.dummy != 5'h00) state <= QFD_ST_DUMMY;
          else if (dec_frame.data != qfd_pkg::QFD_DATA_NONE) state <= QFD_ST_DATA;
          else state <= QFD_ST_IDLE;
        end
        QFD_ST_ADDR: if (byte_done) begin
          addr <= {addr[23:0], next_shreg};
          addr_left <= addr_left - 3'h1;
          if (addr_left == 3'h1) begin
            bitcnt <= 3'h0;
            if (frame.dummy != 5'h00) state <= QFD_ST_DUMMY;
            else if (frame.data != qfd_pkg::QFD_DATA_NONE) state <= QFD_ST_DATA;
            else state <= QFD_ST_IDLE;
          end
        end
        QFD_ST_DUMMY: begin
          bitcnt <= 3'h0;
          dummy_left <= dummy_left - 5'h01;
          if (dummy_left == 5'h01) state <= QFD_ST_DATA;
        end
        QFD_ST_DATA: if (byte_done) begin
          if (frame.data == qfd_pkg::QFD_DATA_IN) begin
            last_byte <= next_shreg;
            if (data_count != qfd_pkg::PROG_MAX) data_count <= data_count + 9'h001;
            if (opcode == qfd_pkg::OP_WR_STAT || opcode == qfd_pkg::OP_WR_EXTA ||
                opcode == qfd_pkg::OP_WR_NVCFG || opcode == qfd_pkg::OP_WR_VCFG) begin
              state <= QFD_ST_IDLE;
            end
          end else begin
            data_count <= data_count + 9'h001;
            if (frame.data == qfd_pkg::QFD_DATA_OUT_ONE) state <= QFD_ST_IDLE;
          end
        end
        QFD_ST_IDLE: bitcnt <= bitcnt + 3'h1; // Still track byte boundary, one bit per clock, so exact on a single lane only
        default: state <= QFD_ST_IDLE;
      endcase
    end
  end

  // Output shifter on falling edge so host samples a stable rising edge
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      out_byte <= 8'h00;
      out_hi <= 1'b0;
      dq_out <= 4'h0;
      dq_oe_out <= 4'h0;
      nib_byte <= 8'h00;
    end else if (state == QFD_ST_DATA && frame.data != qfd_pkg::QFD_DATA_IN) begin
      // Register reads repeat one byte; array reads stream mem_byte_in
      if (frame.quad_data) begin
        nib_byte <= out_hi ? nib_byte : src_byte;
        dq_out <= out_hi ? nib_byte[3:0] : src_byte[7:4];
        out_hi <= ~out_hi;
        dq_oe_out <= 4'hf;
      end else begin
        out_byte <= (bitcnt == 3'h0) ? {src_byte[6:0], 1'b0} : {out_byte[6:0], 1'b0};
        dq_out <= {2'b00, (bitcnt == 3'h0) ? src_byte[7] : out_byte[7], 1'b0};
        dq_oe_out <= 4'h2;
      end
    end else begin
      dq_oe_out <= 4'h0;
      dq_out <= 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handoff of a finished command to the core clock by toggle
  logic done_tgl;
  logic [2:0] done_sync;
  logic cs_sync1;
  logic cs_sync2;
  qfd_pkg::qfd_cmd_t cmd_hold;

  // Deselect captures frame; accepted only on byte boundary
  always_ff @(posedge cs_n_in or posedge srst_in) begin
    if (srst_in) begin
      done_tgl <= 1'b0; // Known start, else the core sees unknown edges
      cmd_hold <= '0;
    end else if (frame.known && (bitcnt == 3'h0) &&
        (frame.opcode_only_reject || frame.data != qfd_pkg::QFD_DATA_NONE ||
         state == QFD_ST_IDLE)) begin
      cmd_hold <= '{opcode: opcode, addr: addr, data_count: data_count, last_byte: last_byte};
      done_tgl <= ~done_tgl;
    end
  end

  // Core side: toggle synchroniser, capture held command once stable
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      done_sync <= 3'h0;
      cs_sync1 <= 1'b1;
      cs_sync2 <= 1'b1;
      cmd_valid_out <= 1'b0;
      cmd_out <= '0;
    end else begin
      done_sync <= {done_sync[1:0], done_tgl};
      cs_sync1 <= cs_n_in;
      cs_sync2 <= cs_sync1;
      cmd_valid_out <= done_sync[2] ^ done_sync[1];
      if (done_sync[2] ^ done_sync[1]) cmd_out <= cmd_hold;
    end
  end

  // Four-byte address mode, changed only by its two opcodes
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      addr4_out <= 1'b0;
    end else if (done_sync[2] ^ done_sync[1]) begin
      if (cmd_hold.opcode == qfd_pkg::OP_EN4B) addr4_out <= 1'b1;
      else if (cmd_hold.opcode == qfd_pkg::OP_DIS4B) addr4_out <= 1'b0;
    end
  end

endmodule // qfd_decoder
`default_nettype wire

/* File: tb/qfd_props.sv */
// Checker for the command decoder, watching its ports only.
`default_nettype none
module qfd_props (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic cs_n_in,
  input wire logic [3:0] dq_oe_out,
  input wire logic cmd_valid_out,
  input wire qfd_pkg::qfd_cmd_t cmd_out,
  input wire logic addr4_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  ////////////////////////////////////////////////////////////////////////////
  // Mode change commands
  sequence s_en4;
    cmd_valid_out && cmd_out.opcode == qfd_pkg::OP_EN4B;
  endsequence
  sequence s_dis4;
    cmd_valid_out && cmd_out.opcode == qfd_pkg::OP_DIS4B;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_oe_deselect: assert property (cs_n_in && $past(cs_n_in) |-> dq_oe_out == 4'h0)
    else $error("lanes driven while deselected");
  a_oe_lane_legal: assert property (dq_oe_out inside {4'h0, 4'h2, 4'hf})
    else $error("illegal lane enable pattern");
  a_valid_one_pulse: assert property (cmd_valid_out |=> !cmd_valid_out)
    else $error("command pulse longer than one cycle");
  a_valid_after_desel: assert property (cmd_valid_out |-> cs_n_in && $past(cs_n_in, 2))
    else $error("command reported while selected");
  a_en4_sets: assert property (s_en4 |-> ##[1:2] addr4_out)
    else $error("four byte mode not entered");
  a_dis4_clears: assert property (s_dis4 |-> ##[1:2] !addr4_out)
    else $error("four byte mode not left");
  a_addr4_hold: assert property (!cmd_valid_out |-> $stable(addr4_out))
    else $error("address mode changed without command");
  a_cmd_hold: assert property (!$stable(cmd_out)
    |-> ##[0:1] (cmd_valid_out || $past(cmd_valid_out, 2)))
    else $error("command record changed without pulse");
endmodule // qfd_props
`default_nettype wire

/* File: tb/qfd_host.sv */
// Behavioural host flash controller driving the serial link.
`default_nettype none
module qfd_host (
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] dq_out,
  input wire logic [3:0] wire_in,
  input wire logic [3:0] oe_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx;
  logic oe_seen;
  // Clock stands low between frames
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    dq_out = 4'h0;
    rx = 8'h00;
    oe_seen = 1'b0;
  end
  // One 80 ns cycle; released lanes toggle so a stale value never matches
  task automatic cyc(input logic [3:0] v, input logic [3:0] m, input bit q);
    dq_out = (v & m) | (~dq_out & ~m);
    #40 sclk_out = 1'b1;
    rx = q ? {rx[3:0], wire_in} : {rx[6:0], wire_in[1]};
    oe_seen = oe_seen | (|oe_in);
    #40 sclk_out = 1'b0;
  endtask
  // Whole byte, high bit or high nibble first
  task automatic put(input logic [7:0] tx, input bit q);
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      if (q) cyc(tx[7-4*i -: 4], 4'hf, 1'b1);
      else cyc({3'h0, tx[7-i]}, 4'h1, 1'b0);
    end
  endtask
  task automatic get(input bit q);
    for (int i = 0; i < (q ? 2 : 8); i++) cyc(4'h0, 4'h0, q);
  endtask
  task automatic dummy(input int n);
    oe_seen = 1'b0;
    repeat (n) cyc(4'h0, 4'h0, 1'b0);
  endtask
  task automatic start();
    oe_seen = 1'b0;
    cs_n_out = 1'b0;
    #40;
  endtask
  task automatic stop();
    #40 cs_n_out = 1'b1;
  endtask
endmodule // qfd_host
`default_nettype wire

/* File: tb/quad_serial_flash_cmd_decoder_test.sv */
// Self-checking bench for the quad serial flash command decoder.
`default_nettype none
module quad_serial_flash_cmd_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b0;
  logic quad_mode = 1'b0;
  logic [7:0] stat_b = 8'h00, flag_b = 8'h00, exta_b = 8'h00, cfg_b = 8'h00, mem_b = 8'h00;
  logic sclk, cs_n, cmd_valid, addr4;
  logic [3:0] h_dq, dq_d, dq_oe, dq_w;
  qfd_pkg::qfd_cmd_t cmd;
  int failures = 0, check_count = 0, cycles = 0;
  logic got;
  // Wire level from both drivers
  assign dq_w = (dq_oe & dq_d) | (~dq_oe & h_dq);
  always #50 core_clk_in = ~core_clk_in;
  qfd_decoder uut (.core_clk_in(core_clk_in), .srst_in(srst_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .dq_in(dq_w), .dq_out(dq_d), .dq_oe_out(dq_oe),
    .quad_mode_in(quad_mode), .stat_reg_in(stat_b), .flag_reg_in(flag_b),
    .exta_reg_in(exta_b), .cfg_reg_in(cfg_b), .mem_byte_in(mem_b),
    .cmd_valid_out(cmd_valid), .cmd_out(cmd), .addr4_out(addr4));
  qfd_host h (.sclk_out(sclk), .cs_n_out(cs_n), .dq_out(h_dq), .wire_in(dq_w), .oe_in(dq_oe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Deselect, then watch long enough for the pulse and the idle gap
  task automatic finish_frame();
    h.stop();
    got = 1'b0;
    repeat (8) begin
      @(posedge core_clk_in);
      #1;
      if (cmd_valid === 1'b1) got = 1'b1;
    end
  endtask
  task automatic addr(input logic [31:0] a, input int n, input bit q);
    for (int i = 0; i < n; i++) h.put(a[8*(n-1-i) +: 8], q);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_opcode_only();
    logic [7:0] ops [7] = '{8'h06, 8'h04, 8'h50, 8'h75, 8'h7a, 8'h7e, 8'h98};
    foreach (ops[i]) begin
      h.start();
      h.put(ops[i], 1'b0);
      finish_frame();
      check(got, 1'b1);
      check(cmd.opcode, ops[i]);
      check(h.oe_seen, 1'b0);
    end
    $display("opcode only done");
  endtask
  // Address length follows the mode; four byte forms ignore it
  task automatic t_addr_mode();
    logic [7:0] ops [4] = '{8'hb7, 8'h20, 8'he9, 8'h20};
    int nab [4] = '{0, 4, 0, 3};
    logic [31:0] exp [4] = '{32'h0, 32'h12345678, 32'h0, 32'h00abcdef};
    foreach (ops[i]) begin
      h.start();
      h.put(ops[i], 1'b0);
      addr(exp[i], nab[i], 1'b0);
      finish_frame();
      if (nab[i] == 0) check(addr4, i == 0);
      else check(cmd.addr, exp[i]);
    end
    h.start();
    h.put(8'h21, 1'b0);
    addr(32'h87654321, 4, 1'b0);
    finish_frame();
    check(cmd.addr, 32'h87654321);
    $display("address mode done");
  endtask
  task automatic t_reg_read();
    logic [7:0] ops [3] = '{8'h05, 8'h70, 8'hc8};
    logic [7:0] val [3] = '{8'ha5, 8'h3c, 8'h81};
    @(posedge core_clk_in);
    stat_b <= val[0];
    flag_b <= val[1];
    exta_b <= val[2];
    foreach (ops[i]) begin
      h.start();
      h.put(ops[i], 1'b0);
      h.get(1'b0);
      check(h.rx, val[i]);
      h.get(1'b0);
      check(h.rx, val[i]);
      finish_frame();
      check(dq_oe, 4'h0);
    end
    $display("register read done");
  endtask
  // Reads with dummies: single lane config, then the quad forms
  task automatic t_dummy_reads();
    logic [7:0] ops [5] = '{8'hb5, 8'h85, 8'h6c, 8'hec, 8'hee};
    int nab [5] = '{3, 3, 4, 4, 4};
    int nd [5] = '{8, 8, 8, 6, 6};
    bit qa [5] = '{0, 0, 0, 1, 1};
    bit qd [5] = '{0, 0, 1, 1, 1};
    @(posedge core_clk_in);
    cfg_b <= 8'h5a;
    mem_b <= 8'h96;
    foreach (ops[i]) begin
      h.start();
      h.put(ops[i], 1'b0);
      addr(32'h00010203, nab[i], qa[i]);
      h.dummy(nd[i]);
      check(h.oe_seen, 1'b0);
      h.get(qd[i]);
      #1;
      check(h.rx, qd[i] ? 8'h96 : 8'h5a);
      check(dq_oe, qd[i] ? 4'hf : 4'h0);
      finish_frame();
      check(dq_oe, 4'h0);
    end
    $display("dummy reads done");
  endtask
  // Host keeps the write framing: address, then whole data bytes
  task automatic t_writes();
    logic [7:0] ops [4] = '{8'h02, 8'h12, 8'h01, 8'hb1};
    int nab [4] = '{3, 4, 0, 3};
    int nb [4] = '{3, 1, 1, 1};
    foreach (ops[i]) begin
      h.start();
      h.put(ops[i], 1'b0);
      addr(32'h00040506, nab[i], 1'b0);
      for (int b = 0; b < nb[i]; b++) h.put(8'ha1 + b, 1'b0);
      finish_frame();
      check(got, 1'b1);
      check(cmd.data_count, nb[i]);
      check(cmd.last_byte, 8'ha0 + nb[i]);
    end
    $display("writes done");
  endtask
  task automatic t_reject();
    h.start();
    h.put(8'h06, 1'b0);
    h.cyc(4'h0, 4'h1, 1'b0); // One clock past the byte boundary
    finish_frame();
    check(got, 1'b0);
    h.start();
    h.put(8'h00, 1'b0);
    h.put(8'hff, 1'b0);
    check(h.oe_seen, 1'b0);
    finish_frame();
    check(got, 1'b0);
    check(addr4, 1'b0);
    $display("reject done");
  endtask
  task automatic t_quad_mode();
    @(posedge core_clk_in);
    quad_mode <= 1'b1;
    h.start();
    h.put(8'h66, 1'b1);
    finish_frame();
    check(cmd.opcode, 8'h66);
    h.start();
    h.put(8'h9f, 1'b1);
    check(h.oe_seen, 1'b0);
    h.get(1'b1);
    #1;
    check(h.rx, 8'h96);
    check(dq_oe, 4'hf);
    finish_frame();
    @(posedge core_clk_in);
    quad_mode <= 1'b0;
    $display("quad mode done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, far above the expected run length
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    srst_in <= 1'b1; // Real edge, clears the deselect-side toggle
    repeat (5) @(posedge core_clk_in);
    srst_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    t_opcode_only();
    t_addr_mode();
    t_reg_read();
    t_dummy_reads();
    t_writes();
    t_reject();
    t_quad_mode();
    final_report();
  end
endmodule // quad_serial_flash_cmd_decoder_test
bind qfd_decoder qfd_props chk (.core_clk_in(core_clk_in), .srst_in(srst_in),
  .cs_n_in(cs_n_in), .dq_oe_out(dq_oe_out), .cmd_valid_out(cmd_valid_out),
  .cmd_out(cmd_out), .addr4_out(addr4_out));
`default_nettype wire
